// *** src/rxs_pkg.sv ***
// Constants and carrier types for the reset and external bus strobe block.
// Assumes one system clock at 250 MHz standing in for the oscillator input.
package rxs_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned RESET_HOLD_OSC   = 24;
  localparam logic [4:0]  RESET_HOLD_CNT   = 5'(RESET_HOLD_OSC);
  localparam logic [4:0]  RESET_OUT_CNT    = 5'(RESET_HOLD_OSC);
  localparam int unsigned MACHINE_OSC      = 12;
  localparam logic [3:0]  PHASE_LAST       = 4'(MACHINE_OSC - 1);
  localparam logic [3:0]  PHASE_ALE0       = 4'h0;
  localparam logic [3:0]  PHASE_ALE1       = 4'h6;
  localparam logic [3:0]  PHASE_ADDR_END   = 4'h2;
  localparam logic [15:0] INTERNAL_LIMIT   = 16'h2000;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic        fetchReq;
    logic [15:0] fetchAddr;
    logic        dataReq;
    logic        dataWrite;
    logic [15:0] dataAddr;
    logic [7:0]  dataOut;
  } rxs_req_t;

  typedef struct packed {
    logic [7:0] lowOut;
    logic [7:0] lowOe;
    logic [7:0] highAddr;
    logic       addrLatch;
    logic       programFetchStrobeN;
    logic       writeStrobeN;
    logic       readStrobeN;
  } rxs_bus_t;

  typedef enum logic [1:0] {
    CYC_IDLE  = 2'b00,
    CYC_FETCH = 2'b01,
    CYC_DATA  = 2'b10
  } rxs_cyc_t;

endpackage

// *** src/rxs_reset_filter.sv ***
// Reset pin qualifier and outward reset pulse generator.
// Assumes resetPinIn synchronous to sys_clk; clock counts oscillator periods.
`timescale 1ns/10ps
module rxs_reset_filter (
  input  wire logic sys_clk,
  input  wire logic rstSyncN,
  input  wire logic resetPinIn,
  input  wire logic watchdogOverflow,
  output logic      coreReset,
  output logic      resetPinOut,
  output logic      resetPinOe
);

  // ==========================================================================
  // Hold counter and pulse counter
  // ==========================================================================
  logic [4:0] holdCnt_q, holdCnt_d;
  logic [4:0] pulseCnt_q, pulseCnt_d;
  logic       coreReset_q, coreReset_d;

  always_comb begin
    holdCnt_d   = holdCnt_q;
    pulseCnt_d  = pulseCnt_q;
    coreReset_d = coreReset_q;
    if (watchdogOverflow) begin
      pulseCnt_d  = rxs_pkg::RESET_OUT_CNT;
      coreReset_d = 1'b1;
    end else if (pulseCnt_q != 5'h0_0) begin
      pulseCnt_d = pulseCnt_q - 5'h0_1;
    end
    if (!resetPinIn) begin
      holdCnt_d = 5'h0_0;
      if (pulseCnt_q == 5'h0_0 && !watchdogOverflow) begin
        coreReset_d = 1'b0;
      end
    end else if (holdCnt_q != rxs_pkg::RESET_HOLD_CNT) begin
      holdCnt_d = holdCnt_q + 5'h0_1;
      if (holdCnt_q == rxs_pkg::RESET_HOLD_CNT - 5'h0_1) begin
        coreReset_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      holdCnt_q   <= 5'h0_0;
      pulseCnt_q  <= 5'h0_0;
      coreReset_q <= 1'b1;
    end else begin
      holdCnt_q   <= holdCnt_d;
      pulseCnt_q  <= pulseCnt_d;
      coreReset_q <= coreReset_d;
    end
  end

  assign coreReset   = coreReset_q;
  assign resetPinOut = (pulseCnt_q != 5'h0_0);
  assign resetPinOe  = (pulseCnt_q != 5'h0_0);

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_hold_resets: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    (resetPinIn && holdCnt_q == rxs_pkg::RESET_HOLD_CNT - 5'h0_1) |=> coreReset_q)
    else $error("Reset not entered after hold time");
  a_wdog_pulse: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    watchdogOverflow |=> resetPinOe [*8])
    else $error("Watchdog reset pulse too short");

endmodule

// *** src/rxs_top.sv ***
// Reset entry, clock halving and external memory strobe sequencer.
// Assumes the core presents requests in rxs_req_t and holds them until done.
`timescale 1ns/10ps
module rxs_top (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             resetPinIn,
  input  wire logic             watchdog_timer_ovf,
  input  wire logic             external_fetch_select,
  input  wire rxs_pkg::rxs_req_t coreReq,
  input  wire logic [7:0]       lowIn,
  output logic                  resetPinOut,
  output logic                  resetPinOe,
  output logic                  coreReset,
  output logic                  internalClk,
  output logic                  fetchExternal,
  output logic                  reqDone,
  output logic [7:0]            readData,
  output rxs_pkg::rxs_bus_t     busOut
);

  // ==========================================================================
  // Reset synchroniser
  // ==========================================================================
  logic rstMeta_q;
  logic rstSyncN;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_q <= 1'b0;
      rstSyncN  <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSyncN  <= rstMeta_q;
    end
  end

  logic coreResetW;
  logic pinOutW;
  logic pinOeW;
  rxs_reset_filter uFilter (
    .sys_clk          (sys_clk),
    .rstSyncN         (rstSyncN),
    .resetPinIn       (resetPinIn),
    .watchdogOverflow (watchdog_timer_ovf),
    .coreReset        (coreResetW),
    .resetPinOut      (pinOutW),
    .resetPinOe       (pinOeW)
  );

  // ==========================================================================
  // Reset outputs, clock halving, fetch select latch
  // ==========================================================================
  logic clkHalf_q, clkHalf_d;
  logic extSel_q, extSel_d;
  logic resetOut_q, resetOe_q, coreRst_q;

  always_comb begin
    clkHalf_d = coreResetW ? 1'b0 : ~clkHalf_q;
    extSel_d  = coreResetW ? external_fetch_select : extSel_q;
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      clkHalf_q  <= 1'b0;
      extSel_q   <= 1'b0;
      resetOut_q <= 1'b0;
      resetOe_q  <= 1'b0;
      coreRst_q  <= 1'b1;
    end else begin
      clkHalf_q  <= clkHalf_d;
      extSel_q   <= extSel_d;
      resetOut_q <= pinOutW;
      resetOe_q  <= pinOeW;
      coreRst_q  <= coreResetW;
    end
  end

  assign internalClk = clkHalf_q;
  assign resetPinOut = resetOut_q;
  assign resetPinOe  = resetOe_q;
  assign coreReset   = coreRst_q;

  function automatic logic isExternal(input logic sel, input logic [15:0] pc);
    isExternal = !sel || (pc >= rxs_pkg::INTERNAL_LIMIT);
  endfunction

  // ==========================================================================
  // Strobe sequencer: twelve-period machine cycle
  // ==========================================================================
  logic [3:0]       phase_q, phase_d;
  rxs_pkg::rxs_cyc_t cyc_q, cyc_d;
  rxs_pkg::rxs_bus_t bus_q, bus_d;
  logic             done_q, done_d;
  logic [7:0]       rdata_q, rdata_d;
  logic             fetchExt_q, fetchExt_d;
  logic             aleSlot;
  logic             aleSkip;

  always_comb begin
    phase_d    = (phase_q == rxs_pkg::PHASE_LAST) ? 4'h0 : phase_q + 4'h1;
    cyc_d      = cyc_q;
    bus_d      = bus_q;
    done_d     = 1'b0;
    rdata_d    = rdata_q;
    fetchExt_d = isExternal(extSel_q, coreReq.fetchAddr);
    aleSlot    = (phase_q == rxs_pkg::PHASE_ALE0) || (phase_q == rxs_pkg::PHASE_ALE1);
    // Data cycle keeps its address pulse, drops the second one
    aleSkip    = (phase_q == rxs_pkg::PHASE_ALE1) && (cyc_q == rxs_pkg::CYC_DATA);
    bus_d.addrLatch = aleSlot && !aleSkip;
    if (phase_q == rxs_pkg::PHASE_LAST) begin
      bus_d.programFetchStrobeN = 1'b1;
      bus_d.writeStrobeN        = 1'b1;
      bus_d.readStrobeN         = 1'b1;
      bus_d.lowOe               = 8'h0_0;
      cyc_d = rxs_pkg::CYC_IDLE;
      // Request still held at done is not taken in that slot, but is taken again at the next PHASE_LAST
      if (cyc_q != rxs_pkg::CYC_IDLE) begin
        done_d = 1'b1;
      end else if (coreReq.dataReq) begin
        cyc_d          = rxs_pkg::CYC_DATA;
        bus_d.lowOut   = coreReq.dataAddr[7:0];
        bus_d.lowOe    = 8'hF_F;
        bus_d.highAddr = coreReq.dataAddr[15:8];
      end else if (coreReq.fetchReq && fetchExt_d) begin
        cyc_d          = rxs_pkg::CYC_FETCH;
        bus_d.lowOut   = coreReq.fetchAddr[7:0];
        bus_d.lowOe    = 8'hF_F;
        bus_d.highAddr = coreReq.fetchAddr[15:8];
      end
    end else if (phase_q == rxs_pkg::PHASE_ADDR_END) begin
      if (cyc_q == rxs_pkg::CYC_FETCH) begin
        bus_d.lowOe               = 8'h0_0;
        bus_d.programFetchStrobeN = 1'b0;
      end else if (cyc_q == rxs_pkg::CYC_DATA) begin
        bus_d.lowOut       = coreReq.dataOut;
        bus_d.lowOe        = coreReq.dataWrite ? 8'hF_F : 8'h0_0;
        bus_d.writeStrobeN = !coreReq.dataWrite;
        bus_d.readStrobeN  = coreReq.dataWrite;
      end
    end else if (phase_q == rxs_pkg::PHASE_LAST - 4'h1 && cyc_q != rxs_pkg::CYC_IDLE) begin
      rdata_d = lowIn;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      phase_q    <= 4'h0;
      cyc_q      <= rxs_pkg::CYC_IDLE;
      bus_q      <= '{lowOut: 8'h0_0, lowOe: 8'h0_0, highAddr: 8'h0_0, addrLatch: 1'b0,
                      programFetchStrobeN: 1'b1, writeStrobeN: 1'b1, readStrobeN: 1'b1};
      done_q     <= 1'b0;
      rdata_q    <= 8'h0_0;
      fetchExt_q <= 1'b0;
    end else if (coreResetW) begin
      phase_q    <= 4'h0;
      cyc_q      <= rxs_pkg::CYC_IDLE;
      bus_q      <= '{lowOut: 8'h0_0, lowOe: 8'h0_0, highAddr: 8'h0_0, addrLatch: 1'b0,
                      programFetchStrobeN: 1'b1, writeStrobeN: 1'b1, readStrobeN: 1'b1};
      done_q     <= 1'b0;
      rdata_q    <= rdata_q;
      fetchExt_q <= fetchExt_d;
    end else begin
      phase_q    <= phase_d;
      cyc_q      <= cyc_d;
      bus_q      <= bus_d;
      done_q     <= done_d;
      rdata_q    <= rdata_d;
      fetchExt_q <= fetchExt_d;
    end
  end

  assign busOut        = bus_q;
  assign reqDone       = done_q;
  assign readData      = rdata_q;
  assign fetchExternal = fetchExt_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_clock_halves: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    !coreResetW && !$past(coreResetW) |-> internalClk != $past(internalClk))
    else $error("Internal clock did not toggle");
  a_ale_period: assert property (@(posedge sys_clk) disable iff (!rstSyncN || coreResetW)
    $rose(busOut.addrLatch) && cyc_q == rxs_pkg::CYC_IDLE && !coreReq.dataReq
      |-> ##6 (busOut.addrLatch || cyc_q == rxs_pkg::CYC_DATA))
    else $error("Latch strobe not every six periods");
  a_ale_skip: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    cyc_q == rxs_pkg::CYC_DATA && phase_q == rxs_pkg::PHASE_ALE1 |=> !busOut.addrLatch)
    else $error("Latch strobe during data cycle");
  a_ale_addr: assert property (@(posedge sys_clk) disable iff (!rstSyncN || coreResetW)
    cyc_q == rxs_pkg::CYC_DATA && phase_q == rxs_pkg::PHASE_ALE0
      |=> busOut.addrLatch && busOut.lowOut == coreReq.dataAddr[7:0])
    else $error("Data address not latched");
  a_fetch_low: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    !busOut.programFetchStrobeN |-> cyc_q == rxs_pkg::CYC_FETCH)
    else $error("Fetch strobe outside fetch");
  a_int_region: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    extSel_q && coreReq.fetchAddr < rxs_pkg::INTERNAL_LIMIT |=> !fetchExternal)
    else $error("Internal fetch sent outside");
  a_ext_all: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    !extSel_q |=> fetchExternal)
    else $error("Fetch not external with select low");
  a_strobe_excl: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    !(busOut.writeStrobeN == 1'b0 && busOut.readStrobeN == 1'b0))
    else $error("Read and write strobes together");
  a_sel_frozen: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    !coreResetW |=> extSel_q == $past(extSel_q))
    else $error("Fetch select changed after reset");
  a_high_addr: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    cyc_q == rxs_pkg::CYC_DATA && phase_q == 4'h1 |-> busOut.highAddr == coreReq.dataAddr[15:8])
    else $error("High address byte wrong");

endmodule

// *** tb/reset_and_external_bus_strobes_tb_top.sv ***
// Self-checking bench for the reset and external bus strobe block.
// Assumes rxs_pkg, rxs_top and the rxs_ext_mem memory model.
`timescale 1ns/10ps
module reset_and_external_bus_strobes_tb_top;
  logic              sys_clk = 1'b0;
  logic              nrst = 1'b0;
  logic              rstDrv = 1'b1;
  logic              resetPinIn;
  logic              wdOvf = 1'b0;
  logic              fetchSel = 1'b1;
  rxs_pkg::rxs_req_t coreReq = '0;
  logic [7:0]        lowIn;
  logic              resetPinOut;
  logic              resetPinOe;
  logic              coreReset;
  logic              internalClk;
  logic              fetchExternal;
  logic              reqDone;
  logic [7:0]        readData;
  rxs_pkg::rxs_bus_t busOut;
  logic [15:0]       lastAddr;
  logic              aleQ = 1'b0;
  logic [15:0]       aleCnt = 16'h0000;
  int                n_errors = 0;
  int                tests_run = 0;
  int                n;
  logic [15:0]       c0;

  // ==========================================================================
  // Clock, pin level and strobe counter
  // ==========================================================================
  always #2 sys_clk = ~sys_clk;
  assign resetPinIn = resetPinOe ? resetPinOut : rstDrv;
  always @(posedge sys_clk) begin
    aleQ <= busOut.addrLatch;
    if (busOut.addrLatch === 1'b1 && aleQ === 1'b0) aleCnt <= aleCnt + 16'h0001;
  end

  rxs_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .resetPinIn(resetPinIn),
    .watchdog_timer_ovf(wdOvf), .external_fetch_select(fetchSel), .coreReq(coreReq),
    .lowIn(lowIn), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .coreReset(coreReset), .internalClk(internalClk), .fetchExternal(fetchExternal),
    .reqDone(reqDone), .readData(readData), .busOut(busOut));
  rxs_ext_mem u_mem (.sys_clk(sys_clk), .busOut(busOut), .lowIn(lowIn), .lastAddr(lastAddr));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_core(input logic v);
    int i;
    for (i = 0; i < 100 && coreReset !== v; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i == 100) begin
      n_errors++;
      test_done();
    end
  endtask

  task automatic do_reset(input logic sel);
    @(posedge sys_clk);
    nrst <= 1'b0;
    rstDrv <= 1'b1;
    fetchSel <= sel;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (30) @(posedge sys_clk);
    rstDrv <= 1'b0;
    wait_core(1'b0);
  endtask

  task automatic do_req(input logic dat, input logic wr, input logic [15:0] a,
                        input logic [7:0] d, input logic ext, output int k);
    @(posedge sys_clk);
    coreReq <= '{fetchReq: !dat, fetchAddr: a, dataReq: dat, dataWrite: wr,
                 dataAddr: a, dataOut: d};
    for (k = 1; k < 40; k++) begin
      @(posedge sys_clk);
      #1;
      if (k == 2 && !dat) chk(fetchExternal, ext);
      if (reqDone === 1'b1) break;
    end
    if (k == 40) begin
      n_errors++;
      test_done();
    end
    @(posedge sys_clk);
    coreReq <= '0;
    k = k + 2;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic test_idle();
    logic prev;
    @(posedge sys_clk);
    #1;
    c0 = aleCnt;
    prev = internalClk;
    repeat (48) begin
      @(posedge sys_clk);
      #1;
      chk(internalClk, !prev);
      prev = internalClk;
    end
    chk(aleCnt - c0, 16'h0008);
    $display("test idle done");
  endtask

  task automatic test_fetch();
    logic seen;
    seen = 1'b0;
    @(posedge sys_clk);
    fetchSel <= 1'b0;
    coreReq <= '{fetchReq: 1'b1, fetchAddr: 16'h1FFF, default: '0};
    repeat (24) begin
      @(posedge sys_clk);
      #1;
      if (reqDone === 1'b1) seen = 1'b1;
    end
    chk(fetchExternal, 1'b0);
    chk(seen, 1'b0);
    @(posedge sys_clk);
    coreReq <= '0;
    do_req(1'b0, 1'b0, 16'h2000, 8'h00, 1'b1, n);
    chk(readData, 8'h1C);
    chk(lastAddr, 16'h2000);
    $display("test fetch done");
  endtask

  task automatic test_data();
    @(posedge sys_clk);
    #1;
    c0 = aleCnt;
    do_req(1'b1, 1'b1, 16'h3456, 8'hA5, 1'b0, n);
    repeat (48 - n) @(posedge sys_clk);
    #1;
    chk(aleCnt - c0, 16'h0007);
    chk(lastAddr, 16'h3456);
    do_req(1'b1, 1'b0, 16'h3456, 8'h00, 1'b0, n);
    chk(readData, 8'hA5);
    $display("test data done");
  endtask

  task automatic test_pin();
    @(posedge sys_clk);
    rstDrv <= 1'b1;
    repeat (23) @(posedge sys_clk);
    rstDrv <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(coreReset, 1'b0);
    @(posedge sys_clk);
    rstDrv <= 1'b1;
    repeat (27) @(posedge sys_clk);
    #1;
    chk(coreReset, 1'b1);
    @(posedge sys_clk);
    rstDrv <= 1'b0;
    wait_core(1'b0);
    $display("test pin reset done");
  endtask

  task automatic test_wdog();
    int c;
    c = 0;
    @(posedge sys_clk);
    wdOvf <= 1'b1;
    @(posedge sys_clk);
    wdOvf <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      #1;
      if (resetPinOe === 1'b1) c++;
      if (i == 4) chk({coreReset, resetPinOut}, 2'b11);
    end
    chk(c >= 24 && c <= 25, 1'b1);
    chk({resetPinOe, resetPinOut}, 2'b00);
    wait_core(1'b0);
    $display("test watchdog done");
  endtask

  task automatic test_sel_low();
    do_reset(1'b0);
    do_req(1'b0, 1'b0, 16'h0100, 8'h00, 1'b1, n);
    chk(readData, 8'h3D);
    chk(lastAddr, 16'h0100);
    $display("test select low done");
  endtask

  initial begin
    do_reset(1'b1);
    test_idle();
    test_fetch();
    test_data();
    test_pin();
    test_wdog();
    test_sel_low();
    test_done();
  end
endmodule

// *** tb/rxs_ext_mem.sv ***
// External program and data memory with an address latch.
// Assumes busOut from the strobe block; returns the port zero wire level.
`timescale 1ns/10ps
module rxs_ext_mem (
  input  wire logic              sys_clk,
  input  wire rxs_pkg::rxs_bus_t busOut,
  output logic [7:0]             lowIn,
  output logic [15:0]            lastAddr
);
  logic [7:0]  latchQ;
  logic [7:0]  floatQ = 8'h00;
  logic [7:0]  extByte;
  logic [7:0]  dmem [256];
  logic [15:0] addr;

  // ==========================================================================
  // Port zero wire level
  // ==========================================================================
  assign addr = {busOut.highAddr, latchQ};
  always_comb begin
    if (!busOut.programFetchStrobeN) extByte = addr[7:0] ^ addr[15:8] ^ 8'h3C;
    else if (!busOut.readStrobeN) extByte = dmem[latchQ];
    else extByte = floatQ;
    lowIn = (busOut.lowOut & busOut.lowOe) | (extByte & ~busOut.lowOe);
  end

  // ==========================================================================
  // Address latch and data store
  // ==========================================================================
  always @(posedge sys_clk) begin
    floatQ <= ~lowIn;
    if (busOut.addrLatch) latchQ <= busOut.lowOut;
    if (!busOut.programFetchStrobeN || !busOut.readStrobeN || !busOut.writeStrobeN) begin
      lastAddr <= addr;
    end
    if (!busOut.writeStrobeN) dmem[latchQ] <= busOut.lowOut;
  end
endmodule
